// file: rtl/adcrp_pkg.sv
// Shared constants, types and helpers of the converter result port
package adcrp_pkg;
  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 100;
  localparam int CONV_TIME_NS = 500;
  localparam int CONV_CYCLES = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] CONV_LAST = 8'(CONV_CYCLES - 1);
  localparam int SCLK_HALF_NS = 200;
  localparam int SCLK_HALF_CYCLES = (SCLK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RESULT_BITS = 16;
  localparam logic [4:0] LAST_BIT = 5'h0F;
  localparam logic [4:0] ALL_BITS = 5'h10;

  // ****************************************
  // Register map and fields
  // ****************************************
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_CLEAR = 8'h08;
  localparam logic [7:0] OFS_ENABLE = 8'h0C;
  localparam logic [7:0] OFS_RESULT = 8'h10;
  localparam logic [4:0] CTRL_RESET = 5'h00;
  localparam logic [2:0] IRQ_RESET = 3'h0;
  localparam int EV_CONV = 0;
  localparam int EV_RDERR = 1;
  localparam int EV_RDDONE = 2;

  // ****************************************
  // Pin positions on the result bus
  // ****************************************
  localparam int PIN_SERIAL_RESULT_OUT = 8;
  localparam int PIN_SCLK = 9;
  localparam int PIN_FRAME = 10;
  localparam int PIN_INCOMPLETE_READ = 11;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [1:0] {
    RD_IDLE = 2'b00,
    RD_SHIFT = 2'b01,
    RD_HOLD = 2'b11
  } adcrp_rd_t;

  typedef struct packed {
    logic frame_polarity_select;
    logic clock_invert_select;
    logic clock_source_select;
    logic output_format_select;
    logic serial_parallel_select;
  } adcrp_ctrl_t;

  typedef struct packed {
    logic chipSelect_n;
    logic read_n;
    logic conversion_start_n;
    logic serialClock;
    logic daisy_chain_in;
  } adcrp_pinin_t;

  typedef struct packed {
    logic [15:0] pinOut;
    logic [15:0] pinOe;
  } adcrp_pins_t;

  // Straight binary when high, two's complement when low
  function automatic logic [15:0] adcrp_fmt(input logic [15:0] raw, input logic straight);
    adcrp_fmt = straight ? raw : {~raw[15], raw[14:0]};
  endfunction
endpackage

// file: rtl/adcrp_sync.sv
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ns
module adcrp_sync #(
  parameter int WIDTH = 5
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Data
  input wire logic [WIDTH-1:0] async,
  output logic [WIDTH-1:0] synced
);
  logic [WIDTH-1:0] stage1;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      stage1 <= '1;
      synced <= '1;
    end else begin
      stage1 <= async;
      synced <= stage1;
    end
  end
endmodule // adcrp_sync

// file: rtl/adcrp_divider.sv
// Tick divider for the master serial clock
`timescale 1ns/1ns
module adcrp_divider #(
  parameter int HALF = 2
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Control
  input wire logic run,
  output logic tick
);
  logic [7:0] count;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      count <= 8'h00;
    end else if (!run || tick) begin
      count <= 8'h00;
    end else begin
      count <= count + 8'h01;
    end
  end

  assign tick = run && (count == 8'(HALF - 1));
endmodule // adcrp_divider

// file: rtl/adc_result_port.sv
// Converter result port: parallel and serial output with APB control
//
// Added by the designer: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ns
// What this block does
// - Select low: bits 8 to 11 act as parallel data outputs.
// - Select high: bits 8 to 11 become data, clock, frame and error.
// - Serial result leaves its shift register most significant bit first.
// - Result encoding follows the output format select.
// - Clock source select decides if the serial clock is driven or taken.
// - Master mode holds each bit across the leading serial clock edge and changes it on the trailing one.
// - Slave, no inversion: data changes on rise, host samples on fall.
// - Slave, inverted: data changes on fall, host samples on rise.
// - Master mode drives a frame signal alongside its own clock.
// - Frame polarity low: frame high while serial data is valid.
// - Frame polarity high: frame low while serial data is valid.
// - Slave read cut by conversion end: data dropped, error pulsed.
// - Bits 12 to 15 stay data outputs in every mode.
// - Busy rises at conversion start, falls once result is loaded.
// - Falling conversion start input begins a conversion.
// - Output drivers on only while chip select and read are low.
// - Slave mode passes daisy input out after sixteen clock periods.
module adc_result_port
  import adcrp_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // APB slave
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Converter core
  input wire logic [15:0] coreResult,
  // Host pins
  input wire logic chipSelect_n,
  input wire logic read_n,
  input wire logic conversion_start_n,
  input wire logic serialClockIn,
  input wire logic daisy_chain_in,
  output adcrp_pins_t dataPins,
  output logic busy,
  // Interrupt
  output logic irq
);
  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    adcrp_ctrl_t ctrl;
    logic [2:0] status;
    logic [2:0] enable;
    logic [15:0] result;
    logic [15:0] shifter;
    logic [4:0] bitCount;
    adcrp_rd_t rd;
    logic busy;
    logic [7:0] convCount;
    logic sclkOut;
    logic sclkPrev;
    logic cnvPrev;
    logic rdErr;
    logic apbAck;
    logic apbErr;
    logic [31:0] prdata;
    adcrp_pins_t pins;
  } adcrp_state_t;

  adcrp_state_t s;
  adcrp_state_t next_s;
  adcrp_pinin_t sIn;
  logic tick;
  logic busEn;
  logic master;
  logic activeEdge;
  logic convDone;
  logic cnvFall;
  logic apbAccess;
  logic apbWrite;
  logic [2:0] ev;

  // ****************************************
  // Pin synchronisers and clock divider
  // ****************************************
  adcrp_sync #(
    .WIDTH(5)
  ) u_sync (
    .clk(clk),
    .reset_n(reset_n),
    .async({chipSelect_n, read_n, conversion_start_n, serialClockIn, daisy_chain_in}),
    .synced(sIn)
  );

  adcrp_divider #(
    .HALF(SCLK_HALF_CYCLES)
  ) u_div (
    .clk(clk),
    .reset_n(reset_n),
    .run(master && s.rd == RD_SHIFT),
    .tick(tick)
  );

  // ****************************************
  // Decodes
  // ****************************************
  assign busEn = !sIn.chipSelect_n && !sIn.read_n;
  assign master = !s.ctrl.clock_source_select;
  assign activeEdge = s.ctrl.clock_invert_select ? (s.sclkPrev && !sIn.serialClock)
                                                 : (!s.sclkPrev && sIn.serialClock);
  assign cnvFall = s.cnvPrev && !sIn.conversion_start_n;
  assign convDone = s.busy && s.convCount == CONV_LAST;
  assign apbAccess = psel && penable && !s.apbAck;
  assign apbWrite = psel && penable && s.apbAck && pwrite;

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    next_s = s;
    ev = 3'h0;
    next_s.rdErr = 1'b0;
    next_s.sclkPrev = sIn.serialClock;
    next_s.cnvPrev = sIn.conversion_start_n;

    // APB
    next_s.apbAck = apbAccess;
    next_s.apbErr = 1'b0;
    if (apbAccess) begin
      unique case (paddr)
        OFS_CTRL: next_s.prdata = {27'h0, s.ctrl};
        OFS_STATUS: next_s.prdata = {29'h0, s.status};
        OFS_ENABLE: next_s.prdata = {29'h0, s.enable};
        OFS_RESULT: next_s.prdata = {16'h0, s.result};
        OFS_CLEAR: next_s.prdata = 32'h0;
        default: begin
          next_s.prdata = 32'h0;
          next_s.apbErr = 1'b1;
        end
      endcase
    end
    if (apbWrite && paddr == OFS_CTRL) begin
      next_s.ctrl = pwdata[4:0];
    end
    if (apbWrite && paddr == OFS_ENABLE) begin
      next_s.enable = pwdata[2:0];
    end

    // Conversion
    if (!s.busy && cnvFall) begin
      next_s.busy = 1'b1;
      next_s.convCount = 8'h00;
    end else if (s.busy) begin
      next_s.convCount = s.convCount + 8'h01;
    end
    if (convDone) begin
      next_s.busy = 1'b0;
      next_s.result = adcrp_fmt(coreResult, s.ctrl.output_format_select);
      ev[EV_CONV] = 1'b1;
      if (s.rd != RD_SHIFT || (!master && s.bitCount != ALL_BITS)) begin
        next_s.shifter = adcrp_fmt(coreResult, s.ctrl.output_format_select);
      end
    end

    // Serial read sequence
    unique case (s.rd)
      RD_IDLE: begin
        next_s.bitCount = 5'h00;
        next_s.sclkOut = 1'b0;
        if (s.ctrl.serial_parallel_select && busEn && (!master || !s.busy)) begin
          next_s.rd = RD_SHIFT;
        end
      end
      RD_SHIFT: begin
        if (!busEn) begin
          next_s.rd = RD_IDLE;
          next_s.bitCount = 5'h00;
        end else if (master) begin
          if (tick && !s.sclkOut) begin
            next_s.sclkOut = 1'b1;
          end else if (tick) begin
            next_s.sclkOut = 1'b0;
            next_s.shifter = {s.shifter[14:0], 1'b0};
            next_s.bitCount = s.bitCount + 5'h01;
            if (s.bitCount == LAST_BIT) begin
              next_s.rd = RD_HOLD;
              ev[EV_RDDONE] = 1'b1;
            end
          end
        end else if (convDone && s.bitCount != 5'h00 && s.bitCount != ALL_BITS) begin
          next_s.rd = RD_HOLD;
          next_s.rdErr = 1'b1;
          ev[EV_RDERR] = 1'b1;
        end else if (activeEdge) begin
          next_s.shifter = {s.shifter[14:0], sIn.daisy_chain_in};
          if (s.bitCount != ALL_BITS) begin
            next_s.bitCount = s.bitCount + 5'h01;
          end
          if (s.bitCount == LAST_BIT) begin
            ev[EV_RDDONE] = 1'b1;
          end
        end
      end
      RD_HOLD: begin
        next_s.sclkOut = 1'b0;
        if (!busEn) begin
          next_s.rd = RD_IDLE;
          next_s.bitCount = 5'h00;
        end
      end
      default: begin
        next_s.rd = RD_IDLE;
      end
    endcase

    // Interrupt status, set wins over clear
    if (apbWrite && paddr == OFS_CLEAR) begin
      next_s.status = s.status & ~pwdata[2:0];
    end
    next_s.status = next_s.status | ev;

    // Pins
    next_s.pins.pinOut = s.result;
    next_s.pins.pinOe = busEn ? 16'hFFFF : 16'h0000;
    if (s.ctrl.serial_parallel_select) begin
      next_s.pins.pinOe = 16'h0000;
      next_s.pins.pinOe[15:12] = {4{busEn}};
      next_s.pins.pinOut[PIN_SERIAL_RESULT_OUT] = s.shifter[15];
      next_s.pins.pinOe[PIN_SERIAL_RESULT_OUT] = busEn;
      next_s.pins.pinOut[PIN_SCLK] = s.sclkOut ^ s.ctrl.clock_invert_select;
      next_s.pins.pinOe[PIN_SCLK] = busEn && master;
      next_s.pins.pinOut[PIN_FRAME] = (s.rd == RD_SHIFT) ^ s.ctrl.frame_polarity_select;
      next_s.pins.pinOe[PIN_FRAME] = busEn && master;
      next_s.pins.pinOut[PIN_INCOMPLETE_READ] = s.rdErr;
      next_s.pins.pinOe[PIN_INCOMPLETE_READ] = busEn && !master;
    end
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s <= '0;
      s.ctrl <= CTRL_RESET;
      s.status <= IRQ_RESET;
      s.enable <= IRQ_RESET;
      s.rd <= RD_IDLE;
      s.sclkPrev <= 1'b1;
      s.cnvPrev <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign prdata = s.prdata;
  assign pready = s.apbAck;
  assign pslverr = s.apbAck && s.apbErr;
  assign dataPins = s.pins;
  assign busy = s.busy;
  assign irq = |(s.status & s.enable);

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  sequence seqStart;
    cnvFall && !s.busy;
  endsequence

  sequence seqConvert;
    busy[*5] ##1 !busy;
  endsequence

  a_busy_start: assert property (seqStart |=> busy)
    else $error("busy did not rise after conversion start");
  a_busy_length: assert property (seqStart |=> seqConvert)
    else $error("busy length wrong");
  a_format_load: assert property (convDone |=> s.result == $past(adcrp_fmt(coreResult, s.ctrl.output_format_select)))
    else $error("result encoding wrong");
  a_par_data: assert property (!s.ctrl.serial_parallel_select |=> dataPins.pinOut == $past(s.result))
    else $error("parallel data wrong");
  a_upper_pins: assert property (busEn |=> dataPins.pinOe[15:12] == 4'hF)
    else $error("upper pins not driven");
  a_bus_off: assert property (!busEn |=> dataPins.pinOe == 16'h0000)
    else $error("pins driven while not selected");
  a_serial_msb: assert property (s.ctrl.serial_parallel_select |=> dataPins.pinOut[8] == $past(s.shifter[15]))
    else $error("serial output not shifter top bit");
  a_sclk_dir: assert property (s.ctrl.serial_parallel_select && !master |=> !dataPins.pinOe[9])
    else $error("serial clock driven in slave mode");
  a_frame_high: assert property (master && s.ctrl.serial_parallel_select && s.rd == RD_SHIFT
      && !s.ctrl.frame_polarity_select |=> dataPins.pinOut[10])
    else $error("frame not high during read");
  a_frame_low: assert property (master && s.ctrl.serial_parallel_select && s.rd == RD_SHIFT
      && s.ctrl.frame_polarity_select |=> !dataPins.pinOut[10])
    else $error("frame not low during read");
  a_master_hold: assert property (master && s.rd == RD_SHIFT && $changed(s.bitCount) |-> $fell(s.sclkOut))
    else $error("master data changed off the falling edge");
  a_slave_edge: assert property (!master && s.rd == RD_SHIFT && s.bitCount != ALL_BITS && !convDone
      && !activeEdge && busEn |=> $stable(s.bitCount))
    else $error("slave data moved without an active edge");
  a_rderr_pulse: assert property (s.rdErr |=> !s.rdErr ##1 dataPins.pinOut[11] == 1'b0)
    else $error("read error not a single pulse");
endmodule // adc_result_port

// file: bench/adcrp_host.sv
// Host controller model that drives and samples the result port pins
`timescale 1ns/1ns
module adcrp_host
  import adcrp_pkg::*;
(
  // Clock
  input wire logic clk,
  // Device pins
  input wire adcrp_pins_t dataPins,
  output logic chipSelect_n,
  output logic read_n,
  output logic conversion_start_n,
  output logic serialClockIn,
  output logic daisy_chain_in
);
  logic prevClk;
  logic prevData;
  logic prevFrame;
  logic held;
  logic [15:0] pinLevel;
  // Undriven pins read back inverted, so a missing enable shows up
  assign pinLevel = dataPins.pinOut ^ ~dataPins.pinOe;
  initial begin
    chipSelect_n = 1'b1;
    read_n = 1'b1;
    conversion_start_n = 1'b1;
    serialClockIn = 1'b1;
    daisy_chain_in = 1'b0;
  end
  // ****************************************
  // Host actions
  // ****************************************
  task automatic start();
    @(posedge clk);
    conversion_start_n <= 1'b0;
    @(posedge clk);
    conversion_start_n <= 1'b1;
  endtask
  // Clock parks at its idle level before the bus opens
  task automatic bus(input logic en, input logic inv);
    @(posedge clk);
    serialClockIn <= !inv;
    repeat (4) @(posedge clk);
    chipSelect_n <= !en;
    read_n <= !en;
  endtask
  // Capture edge samples the bit, active edge moves to the next
  task automatic slave_read(input logic inv, input int n, input logic din, output logic [17:0] got);
    got = '0;
    daisy_chain_in <= din;
    repeat (8) @(posedge clk);
    for (int i = 0; i < n; i++) begin
      @(negedge clk);
      got = {got[16:0], pinLevel[PIN_SERIAL_RESULT_OUT]};
      @(posedge clk);
      serialClockIn <= inv;
      repeat (2) @(posedge clk);
      serialClockIn <= !inv;
      repeat (5) @(posedge clk);
    end
  endtask
  // Bit taken as the clock leaves its idle level, checked again before it returns
  task automatic master_read(input logic pol, input logic inv, output logic [15:0] got, output int bad);
    int edges;
    edges = 0;
    bad = 0;
    got = '0;
    repeat (5) @(negedge clk);
    prevClk = pinLevel[PIN_SCLK];
    prevFrame = pinLevel[PIN_FRAME];
    repeat (120) begin
      @(negedge clk);
      if (edges < 32 && pinLevel[PIN_SCLK] !== prevClk) begin
        edges++;
        if (prevFrame !== !pol) bad++;
        if (prevClk === inv) begin
          held = pinLevel[PIN_SERIAL_RESULT_OUT];
          got = {got[14:0], held};
        end else if (prevData !== held) bad++;
      end
      prevClk = pinLevel[PIN_SCLK];
      prevFrame = pinLevel[PIN_FRAME];
      prevData = pinLevel[PIN_SERIAL_RESULT_OUT];
    end
    if (edges != 32 || pinLevel[PIN_FRAME] !== pol) bad++;
  endtask
endmodule // adcrp_host

// file: bench/testbench.sv
// Self-checking bench of the converter result port
`timescale 1ns/1ns
module testbench
  import adcrp_pkg::*;
;
  logic clk, reset_n, psel, penable, pwrite, pready, pslverr, busy, irq, err;
  logic chipSelect_n, read_n, conversion_start_n, serialClockIn, daisy_chain_in;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd, seed;
  logic [15:0] coreResult, word;
  logic [17:0] got;
  logic [7:0] offs[5] = '{OFS_CTRL, OFS_STATUS, OFS_CLEAR, OFS_ENABLE, 8'h14};
  adcrp_pins_t dataPins;
  int error_cnt, comparisons, cycles, bad, hi, pe;
  int expq[$];
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  adc_result_port dut (.clk(clk), .reset_n(reset_n), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .coreResult(coreResult), .chipSelect_n(chipSelect_n), .read_n(read_n),
    .conversion_start_n(conversion_start_n), .serialClockIn(serialClockIn),
    .daisy_chain_in(daisy_chain_in), .dataPins(dataPins), .busy(busy), .irq(irq));
  adcrp_host host (.clk(clk), .dataPins(dataPins), .chipSelect_n(chipSelect_n), .read_n(read_n),
    .conversion_start_n(conversion_start_n), .serialClockIn(serialClockIn),
    .daisy_chain_in(daisy_chain_in));
  // ****************************************
  // Helpers
  // ****************************************
  task automatic report_and_stop();
    if (error_cnt == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      error_cnt = error_cnt + 1;
      report_and_stop();
    end
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    comparisons = comparisons + 1;
    if (g !== e) begin
      error_cnt = error_cnt + 1;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Starts a conversion, counts busy and error pulse cycles
  task automatic convert(input int ep);
    seed = lfsr(seed);
    @(posedge clk);
    coreResult <= seed[15:0];
    expq.push_back(seed[15:0]);
    host.start();
    hi = 0;
    pe = 0;
    repeat (20) begin
      @(negedge clk);
      if (busy === 1'b1) hi++;
      if (dataPins.pinOut[PIN_INCOMPLETE_READ] === 1'b1) pe++;
    end
    chk(hi, CONV_CYCLES);
    if (ep >= 0) chk(pe, ep);
  endtask
  task automatic irqchk(input logic e);
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk(irq, e);
  endtask
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    reset_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    coreResult = 16'h0000;
    seed = 32'h1D24;
    repeat (16) @(posedge clk);
    reset_n <= 1'b1;
    foreach (offs[i]) begin
      apb(1'b0, offs[i], 32'h0);
      chk(rd, 32'h0);
      chk(err, offs[i] == 8'h14);
    end
    apb(1'b1, OFS_CTRL, 32'h2);
    convert(-1);
    apb(1'b0, OFS_RESULT, 32'h0);
    chk(rd, expq[0]);
    host.bus(1'b1, 1'b0);
    repeat (6) @(posedge clk);
    @(negedge clk);
    chk(dataPins.pinOe, 16'hFFFF);
    chk(dataPins.pinOut, expq.pop_front());
    host.bus(1'b0, 1'b0);
    repeat (6) @(posedge clk);
    @(negedge clk);
    chk(dataPins.pinOe, 16'h0);
    for (int m = 0; m < 2; m++) begin
      apb(1'b1, OFS_CTRL, 32'h1 | (m << 1) | (m << 3) | (m << 4));
      convert(0);
      host.bus(1'b1, 1'b0);
      host.master_read(m[0], m[0], word, bad);
      chk(dataPins.pinOe[15:12], 4'hF);
      chk(dataPins.pinOe[PIN_SCLK], 1'b1);
      chk(bad, 0);
      chk(word, expq.pop_front() ^ (m ? 0 : 32'h8000));
      host.bus(1'b0, 1'b0);
    end
    for (int s = 0; s < 2; s++) begin
      apb(1'b1, OFS_CTRL, 32'h7 | (s << 3));
      convert(0);
      host.bus(1'b1, s[0]);
      host.slave_read(s[0], 18, seed[20], got);
      chk(got, (expq.pop_front() << 2) + (seed[20] ? 3 : 0));
      host.bus(1'b0, s[0]);
    end
    apb(1'b1, OFS_CTRL, 32'h7);
    convert(0);
    host.bus(1'b1, 1'b0);
    host.slave_read(1'b0, 4, 1'b0, got);
    convert(1);
    host.bus(1'b0, 1'b0);
    expq.delete();
    apb(1'b0, OFS_STATUS, 32'h0);
    chk(rd, 32'h7);
    apb(1'b1, OFS_ENABLE, 32'h0);
    irqchk(1'b0);
    apb(1'b1, OFS_ENABLE, 32'h2);
    irqchk(1'b1);
    apb(1'b1, OFS_CLEAR, 32'h2);
    irqchk(1'b0);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk(rd, 32'h5);
    apb(1'b1, OFS_CLEAR, 32'h5);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk(rd, 32'h0);
    report_and_stop();
  end
endmodule // testbench
